// ==== rtl/abx_exec.sv ====
`timescale 1ns/1ps
`include "abx_regs.svh"
module abx_exec #(
  parameter int DEPTH = `ABX_FILE_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire abx_pkg::abx_instr_s instr,
  input wire abx_pkg::abx_load_s load,
  output logic [7:0] acc_r,
  output logic zero_r,
  output logic skip_r,
  output logic [1:0] cycles_r,
  output logic retire_r
);
  import abx_pkg::*;

  logic [7:0] file_mem [DEPTH];
  logic [7:0] operand;
  logic [7:0] and_res;
  logic bit_val;
  abx_state_e state_r;
  logic exec_and;
  logic exec_btc;
  logic run;

  assign operand = file_mem[instr.file_addr];
  assign and_res = acc_r & operand;
  assign bit_val = operand[instr.bit_sel];
  assign run = instr_valid && (state_r == ABX_ST_RUN);
  assign exec_and = run && (instr.op == ABX_OP_AND_ACCUMULATOR_WITH_FILE);
  assign exec_btc = run && (instr.op == ABX_OP_BIT_TEST_SKIP_IF_CLEAR);

  // write back to file; file contents need no reset
  // side load fills the file; an executing and-with-file wins over it only when dest_file is set
  always_ff @(posedge clk) begin
    if (exec_and && instr.dest_file) begin
      file_mem[instr.file_addr] <= and_res;
    end else if (load.file_en) begin
      file_mem[load.addr] <= load.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_r <= `ABX_ACC_RESET;
    end else if (exec_and && !instr.dest_file) begin
      acc_r <= and_res;
    end else if (load.acc_en && !exec_and) begin
      // loads never touch the zero flag, so and-with-file stays its only writer
      acc_r <= load.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      zero_r <= `ABX_ZERO_RESET;
    end else if (exec_and) begin
      zero_r <= (and_res == 8'h00);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ABX_ST_RUN;
    end else begin
      case (state_r)
        ABX_ST_RUN: begin
          if (exec_btc && !bit_val) begin
            state_r <= ABX_ST_SKIP;
          end
        end
        ABX_ST_SKIP: begin
          if (instr_valid) begin
            state_r <= ABX_ST_RUN;
          end
        end
        default: state_r <= ABX_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      skip_r <= 1'b0;
      cycles_r <= `ABX_CYC_ONE;
      retire_r <= 1'b0;
    end else begin
      retire_r <= run;
      if (run) begin
        skip_r <= exec_btc && !bit_val;
        cycles_r <= (exec_btc && !bit_val) ? `ABX_CYC_TWO : `ABX_CYC_ONE;
      end
    end
  end

  property p_skip_keeps;
    @(posedge clk) disable iff (reset)
      (state_r == ABX_ST_SKIP && !load.acc_en) |=> ($stable(zero_r) && $stable(acc_r));
  endproperty
  a_skip_keeps: assert property (p_skip_keeps) else $error("skip altered state");

  property p_zero;
    @(posedge clk) disable iff (reset)
      exec_and |=> (zero_r == ($past(and_res) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_acc_dest;
    @(posedge clk) disable iff (reset)
      (exec_and && !instr.dest_file) |=> (acc_r == $past(and_res));
  endproperty
  a_acc_dest: assert property (p_acc_dest) else $error("accumulator not written");

  property p_file_dest;
    @(posedge clk) disable iff (reset)
      (exec_and && instr.dest_file) |=> $stable(acc_r);
  endproperty
  a_file_dest: assert property (p_file_dest) else $error("accumulator changed");

  property p_and_only_zero;
    @(posedge clk) disable iff (reset)
      (exec_btc && !load.acc_en) |=> ($stable(zero_r) && $stable(acc_r));
  endproperty
  a_and_only_zero: assert property (p_and_only_zero) else $error("bit test changed flags");

  property p_enter_skip;
    @(posedge clk) disable iff (reset)
      (exec_btc && !bit_val) |=> (state_r == ABX_ST_SKIP && cycles_r == `ABX_CYC_TWO);
  endproperty
  a_enter_skip: assert property (p_enter_skip) else $error("skip not entered");

  property p_no_skip;
    @(posedge clk) disable iff (reset)
      (exec_btc && bit_val) |=> (state_r == ABX_ST_RUN && !skip_r);
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skipped on set bit");

  property p_one_cycle;
    @(posedge clk) disable iff (reset)
      (run && !(exec_btc && !bit_val)) |=> (cycles_r == `ABX_CYC_ONE);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("cycle count wrong");

  property p_skip_flag;
    @(posedge clk) disable iff (reset)
      (exec_btc && !bit_val) |=> skip_r;
  endproperty
  a_skip_flag: assert property (p_skip_flag) else $error("skip flag not raised");

  property p_discard;
    @(posedge clk) disable iff (reset)
      (state_r == ABX_ST_SKIP && instr_valid) |=> (!retire_r && state_r == ABX_ST_RUN);
  endproperty
  a_discard: assert property (p_discard) else $error("skipped instruction retired");

  property p_skip_hold;
    @(posedge clk) disable iff (reset)
      (state_r == ABX_ST_SKIP && !instr_valid) |=> (state_r == ABX_ST_SKIP);
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip ended without instruction");

  property p_file_written;
    @(posedge clk) disable iff (reset)
      (exec_and && instr.dest_file) |=>
        (file_mem[$past(instr.file_addr)] == $past(and_res));
  endproperty
  a_file_written: assert property (p_file_written) else $error("file not written");

  property p_zero_clear;
    @(posedge clk) disable iff (reset)
      (exec_and && and_res != 8'h00) |=> !zero_r;
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("zero flag not cleared");

  property p_retire;
    @(posedge clk) disable iff (reset)
      run |=> retire_r;
  endproperty
  a_retire: assert property (p_retire) else $error("instruction not retired");

  property p_btc_file_kept;
    @(posedge clk) disable iff (reset)
      (exec_btc && !load.file_en) |=>
        (file_mem[$past(instr.file_addr)] == $past(operand));
  endproperty
  a_btc_file_kept: assert property (p_btc_file_kept) else $error("bit test wrote file");

  property p_state_onehot;
    @(posedge clk) disable iff (reset)
      $onehot(state_r);
  endproperty
  a_state_onehot: assert property (p_state_onehot) else $error("state not one-hot");

  property p_and_no_skip;
    @(posedge clk) disable iff (reset)
      exec_and |=> (!skip_r && cycles_r == `ABX_CYC_ONE);
  endproperty
  a_and_no_skip: assert property (p_and_no_skip) else $error("and-with-file skipped");
endmodule // abx_exec

// ==== shared/abx_regs.svh ====
`ifndef ABX_REGS_SVH
`define ABX_REGS_SVH
`define ABX_FILE_DEPTH 128
`define ABX_ACC_RESET 8'h00
`define ABX_ZERO_RESET 1'b0
`define ABX_CYC_ONE 2'h1
`define ABX_CYC_TWO 2'h2
`endif

// ==== shared/abx_pkg.sv ====
package abx_pkg;
  typedef enum logic [2:0] {
    ABX_OP_NOP = 3'h1,
    ABX_OP_AND_ACCUMULATOR_WITH_FILE = 3'h2,
    ABX_OP_BIT_TEST_SKIP_IF_CLEAR = 3'h4
  } abx_op_e;
  typedef struct packed {
    abx_op_e op;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic dest_file;
  } abx_instr_s;
  typedef struct packed {
    logic acc_en;
    logic file_en;
    logic [6:0] addr;
    logic [7:0] data;
  } abx_load_s;
  typedef enum logic [1:0] {
    ABX_ST_RUN = 2'h1,
    ABX_ST_SKIP = 2'h2
  } abx_state_e;
endpackage

// ==== sim/abx_exec_tb.sv ====
`timescale 1ns/1ps
module abx_exec_tb;
  import abx_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  abx_instr_s instr = '0;
  abx_load_s load = '0;
  logic [7:0] acc_r;
  logic zero_r, skip_r, retire_r;
  logic [1:0] cycles_r;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  abx_exec dut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr), .load(load),
    .acc_r(acc_r), .zero_r(zero_r), .skip_r(skip_r), .cycles_r(cycles_r), .retire_r(retire_r));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // results are visible right after the taking edge, when the task returns
  task automatic issue(input abx_op_e op, input logic [6:0] a, input logic [2:0] b,
                       input logic d);
    @(posedge clk);
    #1 instr_valid = 1'b1;
    instr = '{op, a, b, d};
    @(posedge clk);
    #1 instr_valid = 1'b0;
  endtask
  // acc resets to zero, so every and-result is zero; file bits are not loaded until t_load
  task automatic t_and;
    issue(ABX_OP_AND_ACCUMULATOR_WITH_FILE, 7'h7F, 3'h0, 1'b0);
    chk("acc", acc_r, 8'h00);
    chk("zero", {7'h00, zero_r}, 8'h01);
    chk("retire", {7'h00, retire_r}, 8'h01);
    chk("cycles", {6'h00, cycles_r}, 8'h01);
    issue(ABX_OP_AND_ACCUMULATOR_WITH_FILE, 7'h00, 3'h0, 1'b1);
    chk("acc dest file", acc_r, 8'h00);
  endtask
  task automatic t_skip;
    issue(ABX_OP_AND_ACCUMULATOR_WITH_FILE, 7'h7F, 3'h0, 1'b1);
    issue(ABX_OP_BIT_TEST_SKIP_IF_CLEAR, 7'h7F, 3'h7, 1'b0);
    chk("skip", {7'h00, skip_r}, 8'h01);
    chk("cycles skip", {6'h00, cycles_r}, 8'h02);
    chk("retire test", {7'h00, retire_r}, 8'h01);
    @(posedge clk);
    #1 chk("retire idle", {7'h00, retire_r}, 8'h00);
    issue(ABX_OP_AND_ACCUMULATOR_WITH_FILE, 7'h00, 3'h0, 1'b0);
    chk("retire discarded", {7'h00, retire_r}, 8'h00);
    chk("zero kept", {7'h00, zero_r}, 8'h01);
    issue(ABX_OP_NOP, 7'h00, 3'h0, 1'b0);
    chk("retire nop", {7'h00, retire_r}, 8'h01);
    chk("cycles nop", {6'h00, cycles_r}, 8'h01);
  endtask
  task automatic ld(input logic ae, input logic fe, input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 load = '{ae, fe, a, v};
    @(posedge clk);
    #1 load = '0;
  endtask
  // nonzero operands: acc F0, file 10 holds 3C
  task automatic t_load;
    ld(1'b1, 1'b0, 7'h00, 8'hF0);
    ld(1'b0, 1'b1, 7'h10, 8'h3C);
    issue(ABX_OP_AND_ACCUMULATOR_WITH_FILE, 7'h10, 3'h0, 1'b0);
    chk("acc and", acc_r, 8'h30);
    chk("zero clear", {7'h00, zero_r}, 8'h00);
    chk("retire and", {7'h00, retire_r}, 8'h01);
    issue(ABX_OP_AND_ACCUMULATOR_WITH_FILE, 7'h10, 3'h0, 1'b1);
    chk("acc kept", acc_r, 8'h30);
    issue(ABX_OP_BIT_TEST_SKIP_IF_CLEAR, 7'h10, 3'h4, 1'b0);
    chk("no skip", {7'h00, skip_r}, 8'h00);
    chk("cycles no skip", {6'h00, cycles_r}, 8'h01);
    chk("retire no skip", {7'h00, retire_r}, 8'h01);
    issue(ABX_OP_BIT_TEST_SKIP_IF_CLEAR, 7'h10, 3'h2, 1'b0);
    chk("file written", {7'h00, skip_r}, 8'h01);
    chk("cycles skip2", {6'h00, cycles_r}, 8'h02);
    issue(ABX_OP_AND_ACCUMULATOR_WITH_FILE, 7'h7F, 3'h0, 1'b0);
    chk("acc not discarded", acc_r, 8'h30);
    chk("zero untouched", {7'h00, zero_r}, 8'h00);
    chk("retire dropped", {7'h00, retire_r}, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ceiling well above the few dozen cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    chk("acc reset", acc_r, 8'h00);
    t_and();
    t_skip();
    t_load();
    report_and_stop();
  end
endmodule // abx_exec_tb
